// ### core/port_ctrl_status_register.sv
// Port controller control and status register, upper half (bits 31 to 13).
//
// Overview of operation
// - Register answers only the local processor at its private address.
// - Bit 31 shows lower key switch; attached processors read 1.
// - Bit 30 shows console source selection, logical or physical.
// - Bit 29 read-only upper key switch; attached processors read 1.
// - Setting bit 28 cycles AC-low and DC-low; DC-low clears it.
// - Bit 27 shows self-test speed selection.
// - Bit 26 shows whether a product test line is absent.
// - Bit 25 cleared by DC-low; microcode sets it after self-test passes.
// - Bit 25 low asserts bad-node and darkens LEDs; high releases, lights.
// - Bit 24 drives the panel run lamp.
// - Bit 23 forces bad even-byte parity and masks even parity errors.
// - Bit 15 forces bad odd-byte parity and masks odd parity errors.
// - Error event code sets lock bit 22, freezing bits 21 to 16.
// - Writing 1 to bit 22 releases lock; writing 0 does nothing.
// - Bit 21 sets two cycles after write acknowledge, clears on other types.
// - Write flag captured together with event code when lock sets.
// - Bits 20 to 16 follow event lines; errors latch and raise machine check.
// - Error codes are 03, 18, 19, 1A, 1C, 1D, 1E and 1F.
// - Cache parity error sets bit 14 and error output; write 1 clears.
// - Bit 13 enables bus pipeline mode.
// - I/O space writes are never pipelined.
`timescale 1ns/1ps
`include "port_ctrl_params.svh"
module port_ctrl_status_register #(
  parameter logic [3:0] RESET_PULSE = `PCS_RESET_PULSE,
  parameter int WRMEM_DELAY = `PCS_WRMEM_DELAY
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // System DC-low from the bus, active low.
  input wire logic dc_power_low_n_i,
  // Processor private-space register access.
  input wire port_ctrl_pkg::reg_req_t req_i,
  output logic [31:0] rdata_o,
  output logic rvalid_o,
  // Panel and off-module signals.
  input wire logic panel_halt_switch_in_i,
  input wire logic panel_console_source_in_i,
  input wire logic panel_console_unlock_in_i,
  input wire logic attached_processor_i,
  input wire logic selftest_speed_in_n_i,
  input wire logic product_test_line_in_n_i,
  // Bus interface chip event lines and transaction reports.
  input wire logic [4:0] bus_event_code_i,
  input wire port_ctrl_pkg::txn_info_t txn_i,
  // Cache and branch buffer parity check results, per byte lane.
  input wire logic [3:0] cache_parity_bad_i,
  input wire logic cache_read_valid_i,
  // System reset and status outputs.
  output logic system_reset_out_n_o,
  output logic ac_power_low_n_o,
  output logic dc_power_low_n_o,
  output logic node_failed_out_n_o,
  output logic [1:0] selftest_led_o,
  output logic run_lamp_out_n_o,
  output logic force_bad_parity_even_o,
  output logic force_bad_parity_odd_o,
  output logic port_error_out_n_o,
  output logic machine_check_o,
  output logic pipeline_enable_o,
  output logic io_write_nopipe_o
);

  // Decode of an error event code.
  function automatic logic is_error_code(input logic [4:0] code);
    unique case (code)
      5'h03, 5'h18, 5'h19, 5'h1A, 5'h1C, 5'h1D, 5'h1E, 5'h1F: is_error_code = 1'b1;
      default: is_error_code = 1'b0;
    endcase
  endfunction

  logic [1:0] sw_meta_q [5];
  logic [4:0] sw_q;
  logic [4:0] sw_raw;
  logic dclo_meta_q;
  logic dclo_q;
  logic dc_clear;
  logic sysrst_q;
  logic stpass_q;
  logic run_q;
  logic bad_even_q;
  logic bad_odd_q;
  logic pipe_q;
  logic lock_q;
  logic wrmem_q;
  logic [4:0] ev_q;
  logic parerr_q;
  logic [WRMEM_DELAY-1:0] ack_pipe_q;
  logic wr_hit;
  logic rd_hit;
  logic err_now;
  logic par_now;
  logic [31:0] csr_view;
  port_ctrl_pkg::rst_state_t rst_state_q;
  logic [3:0] rst_cnt_q;

  // Only the local processor reaches this port, and only at one address.
  assign wr_hit = req_i.wr && (req_i.addr == `PCS_ADDR);
  assign rd_hit = req_i.rd && (req_i.addr == `PCS_ADDR);

  // Attached processors have no key switch wiring, so those bits force to 1.
  assign sw_raw = {panel_halt_switch_in_i | attached_processor_i,
                   panel_console_source_in_i,
                   panel_console_unlock_in_i | attached_processor_i,
                   ~selftest_speed_in_n_i,
                   ~product_test_line_in_n_i};

  // Switch inputs pass three flops before anyone reads them.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 5; i++) begin
        sw_meta_q[i] <= 2'h0;
      end
      sw_q <= 5'h00;
    end else begin
      for (int i = 0; i < 5; i++) begin
        sw_meta_q[i] <= {sw_meta_q[i][0], sw_raw[i]};
        sw_q[i] <= sw_meta_q[i][1];
      end
    end
  end

  // DC-low is synchronised; its low level clears the software state.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dclo_meta_q <= 1'b0;
      dclo_q <= 1'b0;
    end else begin
      dclo_meta_q <= ~dc_power_low_n_i;
      dclo_q <= dclo_meta_q;
    end
  end
  assign dc_clear = dclo_q;

  // Read/write control bits; switch bits are simply not stored, so writes miss them.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sysrst_q <= 1'b0;
      run_q <= 1'b0;
      bad_even_q <= 1'b0;
      bad_odd_q <= 1'b0;
      pipe_q <= 1'b0;
    end else if (dc_clear) begin
      sysrst_q <= 1'b0;
      run_q <= 1'b0;
      bad_even_q <= 1'b0;
      bad_odd_q <= 1'b0;
      pipe_q <= 1'b0;
    end else if (wr_hit) begin
      sysrst_q <= req_i.wdata[`PCS_BIT_SYSRST];
      run_q <= req_i.wdata[`PCS_BIT_RUN];
      bad_even_q <= req_i.wdata[`PCS_BIT_BADEVEN];
      bad_odd_q <= req_i.wdata[`PCS_BIT_BADODD];
      pipe_q <= req_i.wdata[`PCS_BIT_PIPE];
    end
  end

  // Self-test pass is cleared by DC-low or by writing 0; microcode sets it by writing 1.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      stpass_q <= 1'b0;
    end else if (dc_clear) begin
      stpass_q <= 1'b0;
    end else if (wr_hit) begin
      stpass_q <= req_i.wdata[`PCS_BIT_STPASS];
    end
  end

  // System reset sequencer: drop AC-low, then DC-low, as at power-up.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rst_state_q <= port_ctrl_pkg::RS_IDLE;
      rst_cnt_q <= 4'h0;
    end else begin
      unique case (rst_state_q)
        port_ctrl_pkg::RS_IDLE: begin
          if (sysrst_q) begin
            rst_state_q <= port_ctrl_pkg::RS_ACLO;
            rst_cnt_q <= RESET_PULSE;
          end
        end
        port_ctrl_pkg::RS_ACLO: begin
          if (rst_cnt_q == 4'h0) begin
            rst_state_q <= port_ctrl_pkg::RS_DCLO;
            rst_cnt_q <= RESET_PULSE;
          end else begin
            rst_cnt_q <= rst_cnt_q - 4'h1;
          end
        end
        port_ctrl_pkg::RS_DCLO: begin
          // Stay until the returned DC-low has cleared the request bit.
          if (rst_cnt_q == 4'h0) begin
            if (!sysrst_q) begin
              rst_state_q <= port_ctrl_pkg::RS_IDLE;
            end
          end else begin
            rst_cnt_q <= rst_cnt_q - 4'h1;
          end
        end
        default: begin
          rst_state_q <= port_ctrl_pkg::RS_IDLE;
        end
      endcase
    end
  end

  // Memory write flag: acknowledge delayed two cycles.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ack_pipe_q <= '0;
    end else begin
      ack_pipe_q <= {ack_pipe_q[WRMEM_DELAY-2:0], txn_i.ack};
    end
  end

  logic [WRMEM_DELAY-1:0] kind_pipe_q;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      kind_pipe_q <= '0;
    end else begin
      kind_pipe_q <= {kind_pipe_q[WRMEM_DELAY-2:0], txn_i.is_mem_write};
    end
  end

  assign err_now = is_error_code(bus_event_code_i) && !lock_q;

  // Event code, write flag and lock; errors are ignored while locked, so a release write always takes effect.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      lock_q <= 1'b0;
      wrmem_q <= 1'b0;
      ev_q <= 5'h00;
    end else if (dc_clear) begin
      lock_q <= 1'b0;
      wrmem_q <= 1'b0;
      ev_q <= 5'h00;
    end else if (err_now) begin
      lock_q <= 1'b1;
      ev_q <= bus_event_code_i;
      if (ack_pipe_q[WRMEM_DELAY-1]) begin
        wrmem_q <= kind_pipe_q[WRMEM_DELAY-1];
      end
    end else if (lock_q) begin
      // Frozen; only a write of 1 releases it.
      if (wr_hit && req_i.wdata[`PCS_BIT_LOCK]) begin
        lock_q <= 1'b0;
      end
    end else begin
      ev_q <= bus_event_code_i;
      if (ack_pipe_q[WRMEM_DELAY-1]) begin
        wrmem_q <= kind_pipe_q[WRMEM_DELAY-1];
      end
    end
  end

  // Machine check pulse when the lock first sets.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      machine_check_o <= 1'b0;
    end else begin
      machine_check_o <= err_now && !dc_clear;
    end
  end

  // Parity error on unmasked lanes; lanes 0 and 2 are even, 1 and 3 odd.
  assign par_now = cache_read_valid_i &&
                   (|(cache_parity_bad_i & {~bad_odd_q, ~bad_even_q, ~bad_odd_q, ~bad_even_q}));

  // Sticky parity error; a new error beats a write-1 clear.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      parerr_q <= 1'b0;
    end else if (dc_clear) begin
      parerr_q <= 1'b0;
    end else if (par_now) begin
      parerr_q <= 1'b1;
    end else if (wr_hit && req_i.wdata[`PCS_BIT_PARERR]) begin
      parerr_q <= 1'b0;
    end
  end

  // Read view of the register; bits 12 to 0 belong elsewhere and read zero.
  always_comb begin
    csr_view = 32'h0000_0000;
    csr_view[`PCS_BIT_HALT] = sw_q[4];
    csr_view[`PCS_BIT_CSRC] = sw_q[3];
    csr_view[`PCS_BIT_UNLOCK] = sw_q[2];
    csr_view[`PCS_BIT_SYSRST] = sysrst_q;
    csr_view[`PCS_BIT_STSPEED] = sw_q[1];
    csr_view[`PCS_BIT_PTABSENT] = sw_q[0];
    csr_view[`PCS_BIT_STPASS] = stpass_q;
    csr_view[`PCS_BIT_RUN] = run_q;
    csr_view[`PCS_BIT_BADEVEN] = bad_even_q;
    csr_view[`PCS_BIT_LOCK] = lock_q;
    csr_view[`PCS_BIT_WRMEM] = wrmem_q;
    csr_view[`PCS_EV_HI:`PCS_EV_LO] = ev_q;
    csr_view[`PCS_BIT_BADODD] = bad_odd_q;
    csr_view[`PCS_BIT_PARERR] = parerr_q;
    csr_view[`PCS_BIT_PIPE] = pipe_q;
  end

  // Read answer one cycle after the request; misses return zero.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd;
      rdata_o <= rd_hit ? csr_view : 32'h0000_0000;
    end
  end

  // Registered pin drivers.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      system_reset_out_n_o <= 1'b1;
      ac_power_low_n_o <= 1'b1;
      dc_power_low_n_o <= 1'b1;
      node_failed_out_n_o <= 1'b0;
      selftest_led_o <= 2'h0;
      run_lamp_out_n_o <= 1'b1;
      force_bad_parity_even_o <= 1'b0;
      force_bad_parity_odd_o <= 1'b0;
      port_error_out_n_o <= 1'b1;
      pipeline_enable_o <= 1'b0;
      io_write_nopipe_o <= 1'b0;
    end else begin
      system_reset_out_n_o <= ~sysrst_q;
      ac_power_low_n_o <= (rst_state_q != port_ctrl_pkg::RS_ACLO) &&
                          (rst_state_q != port_ctrl_pkg::RS_DCLO);
      dc_power_low_n_o <= (rst_state_q != port_ctrl_pkg::RS_DCLO);
      node_failed_out_n_o <= stpass_q;
      selftest_led_o <= {2{stpass_q}};
      run_lamp_out_n_o <= ~run_q;
      force_bad_parity_even_o <= bad_even_q;
      force_bad_parity_odd_o <= bad_odd_q;
      port_error_out_n_o <= ~(par_now && !dc_clear);
      pipeline_enable_o <= pipe_q && !txn_i.is_io_write;
      io_write_nopipe_o <= txn_i.is_io_write;
    end
  end

endmodule

// ### core/port_ctrl_params.svh
// Address, bit positions and timing counts for the port controller status register.
`ifndef PORT_CTRL_PARAMS_SVH
`define PORT_CTRL_PARAMS_SVH
`define PCS_ADDR 32'h2008_8000
`define PCS_BIT_HALT 31
`define PCS_BIT_CSRC 30
`define PCS_BIT_UNLOCK 29
`define PCS_BIT_SYSRST 28
`define PCS_BIT_STSPEED 27
`define PCS_BIT_PTABSENT 26
`define PCS_BIT_STPASS 25
`define PCS_BIT_RUN 24
`define PCS_BIT_BADEVEN 23
`define PCS_BIT_LOCK 22
`define PCS_BIT_WRMEM 21
`define PCS_EV_HI 20
`define PCS_EV_LO 16
`define PCS_BIT_BADODD 15
`define PCS_BIT_PARERR 14
`define PCS_BIT_PIPE 13
`define PCS_WRMEM_DELAY 2
`define PCS_RESET_PULSE 4'hF
`endif

// ### core/port_ctrl_pkg.sv
// Types shared by the port controller status register.
package port_ctrl_pkg;
  // Processor register access request.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } reg_req_t;
  // Bus interface transaction report.
  typedef struct packed {
    logic ack;
    logic is_mem_write;
    logic is_io_write;
  } txn_info_t;
  // Reset sequencer states.
  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,
    RS_ACLO = 2'b01,
    RS_DCLO = 2'b10
  } rst_state_t;
endpackage

// ### dv/port_ctrl_far_model.sv
// Backplane model that returns the module's DC-low output to its DC-low input.
`timescale 1ns/1ps
module port_ctrl_far_model (
  // Clock.
  input wire logic clock_i,
  // DC-low as driven by the module, and as seen back on the backplane.
  input wire logic dc_loop_i,
  output logic dc_loop_o
);
  // The wired return adds one clock, so the module never sees its own pulse in the same cycle.
  always_ff @(posedge clock_i) begin
    dc_loop_o <= dc_loop_i;
  end
endmodule

// ### dv/port_ctrl_monitor.sv
// Port assertions for the port controller status register.
`timescale 1ns/1ps
module port_ctrl_monitor #(
  parameter logic [3:0] RESET_PULSE = 4'hF,
  parameter int WRMEM_DELAY = 2
) (
  // Clock, reset and register access.
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic dc_power_low_n_i,
  input wire logic rvalid_o,
  input wire port_ctrl_pkg::reg_req_t req_i,
  input wire logic [31:0] rdata_o,
  // Panel, bus and cache inputs.
  input wire logic panel_halt_switch_in_i,
  input wire logic panel_console_source_in_i,
  input wire logic panel_console_unlock_in_i,
  input wire logic attached_processor_i,
  input wire logic selftest_speed_in_n_i,
  input wire logic product_test_line_in_n_i,
  input wire logic [4:0] bus_event_code_i,
  input wire port_ctrl_pkg::txn_info_t txn_i,
  input wire logic [3:0] cache_parity_bad_i,
  input wire logic cache_read_valid_i,
  // Outputs of the register.
  input wire logic system_reset_out_n_o,
  input wire logic ac_power_low_n_o,
  input wire logic dc_power_low_n_o,
  input wire logic node_failed_out_n_o,
  input wire logic [1:0] selftest_led_o,
  input wire logic run_lamp_out_n_o,
  input wire logic force_bad_parity_even_o,
  input wire logic force_bad_parity_odd_o,
  input wire logic port_error_out_n_o,
  input wire logic machine_check_o,
  input wire logic pipeline_enable_o,
  input wire logic io_write_nopipe_o
);
  localparam int AC_SPAN = int'(RESET_PULSE) + 1;
  logic is_err;
  logic par_seen;
  logic lane_valid_q;
  logic [3:0] lane_bad_q;
  logic reg_wr;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  // Lane faults are held one cycle, because the force outputs trail the mask bits by a cycle too.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      lane_valid_q <= 1'b0;
      lane_bad_q <= 4'h0;
    end else begin
      lane_valid_q <= cache_read_valid_i;
      lane_bad_q <= cache_parity_bad_i;
    end
  end
  // Decoded causes; a lane fault only counts when its lane class is not forced bad.
  assign is_err = bus_event_code_i inside {5'h03, 5'h18, 5'h19, 5'h1A, 5'h1C, 5'h1D, 5'h1E, 5'h1F};
  assign par_seen = lane_valid_q && |(lane_bad_q & ~{2{force_bad_parity_odd_o, force_bad_parity_even_o}});
  assign reg_wr = req_i.wr && req_i.addr == 32'h2008_8000 && dc_power_low_n_i;

  a_node_led_tie: assert property (
    selftest_led_o == {2{node_failed_out_n_o}}) else $error("led and node outputs differ");
  a_node_follow: assert property (
    reg_wr |=> ##1 node_failed_out_n_o == $past(req_i.wdata[25], 2)) else $error("bad node output wrong");
  a_foreign_read: assert property (
    req_i.rd && req_i.addr != 32'h2008_8000 |=> rvalid_o && rdata_o == 32'h0) else $error("foreign read answered");
  a_run_lamp: assert property (
    reg_wr |=> ##1 run_lamp_out_n_o == !$past(req_i.wdata[24], 2)) else $error("run lamp wrong");
  a_force_bits: assert property (
    reg_wr |=> ##1 force_bad_parity_even_o == $past(req_i.wdata[23], 2) &&
      force_bad_parity_odd_o == $past(req_i.wdata[15], 2)) else $error("forced parity outputs wrong");
  a_parity_report: assert property (
    par_seen |-> !port_error_out_n_o) else $error("parity fault not reported");
  a_parity_cause: assert property (
    !port_error_out_n_o |-> par_seen) else $error("error output without cause");
  a_mcheck_cause: assert property (
    machine_check_o |-> $past(is_err)) else $error("machine check without error code");
  a_io_nopipe: assert property (
    txn_i.is_io_write |=> !pipeline_enable_o) else $error("pipelined during io write");
  a_dc_inside_ac: assert property (
    !dc_power_low_n_o |-> !ac_power_low_n_o) else $error("dc low outside ac low");
  a_ac_then_dc: assert property (
    $fell(ac_power_low_n_o) |-> ##AC_SPAN $fell(dc_power_low_n_o)) else $error("dc low not after ac span");
endmodule

bind port_ctrl_status_register port_ctrl_monitor #(.RESET_PULSE(RESET_PULSE), .WRMEM_DELAY(WRMEM_DELAY)) u_mon (.*);

// ### dv/testbench.sv
// Self-checking bench for the port controller status register.
`timescale 1ns/1ps
`define CHECK(what, exp, seen) \
  begin checks_done++; if ((seen) !== (exp)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", what, exp, seen); end end
module testbench;
  localparam logic [31:0] ADDR = 32'h2008_8000;
  logic clock_i, rst_i, dc_power_low_n_i, rvalid_o, cache_read_valid_i;
  port_ctrl_pkg::reg_req_t req_i;
  port_ctrl_pkg::txn_info_t txn_i;
  logic [31:0] rdata_o;
  logic panel_halt_switch_in_i, panel_console_source_in_i, panel_console_unlock_in_i, attached_processor_i;
  logic selftest_speed_in_n_i, product_test_line_in_n_i;
  logic [4:0] bus_event_code_i;
  logic [3:0] cache_parity_bad_i;
  logic system_reset_out_n_o, ac_power_low_n_o, dc_power_low_n_o, node_failed_out_n_o, run_lamp_out_n_o;
  logic [1:0] selftest_led_o;
  logic force_bad_parity_even_o, force_bad_parity_odd_o, port_error_out_n_o;
  logic machine_check_o, pipeline_enable_o, io_write_nopipe_o;
  logic [5:0] sw;
  int n_fail = 0;
  int checks_done = 0;

  // Panel and off-module levels move as one group.
  assign {panel_halt_switch_in_i, panel_console_source_in_i, panel_console_unlock_in_i, attached_processor_i,
    selftest_speed_in_n_i, product_test_line_in_n_i} = sw;
  port_ctrl_status_register #(.RESET_PULSE(4'h2)) DUT (.*);
  port_ctrl_far_model far (.clock_i, .dc_loop_i(dc_power_low_n_o), .dc_loop_o(dc_power_low_n_i));

  // Free-running 50 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // Verdict and the way out of a hang.
  task automatic print_verdict();
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic give_up();
    n_fail++;
    print_verdict();
  endtask

  // Register access: one-cycle strobes launched on the falling edge.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge clock_i);
    req_i.wr = 1'b1;
    req_i.addr = a;
    req_i.wdata = d;
    @(negedge clock_i);
    req_i.wr = 1'b0;
  endtask
  task automatic rdchk(input logic [31:0] a, input string what, input logic [31:0] m, input logic [31:0] exp);
    @(negedge clock_i);
    req_i.rd = 1'b1;
    req_i.addr = a;
    @(negedge clock_i);
    req_i.rd = 1'b0;
    for (int i = 0; i < 4 && rvalid_o !== 1'b1; i++) @(negedge clock_i);
    if (rvalid_o !== 1'b1) give_up();
    `CHECK(what, exp & m, rdata_o & m)
  endtask
  task automatic pulse_ack(input logic mem);
    @(negedge clock_i);
    txn_i = '{ack: 1'b1, is_mem_write: mem, is_io_write: 1'b0};
    @(negedge clock_i);
    txn_i.ack = 1'b0;
    repeat (3) @(negedge clock_i);
  endtask

  // Switch bits follow their inputs and shrug off writes.
  task automatic t_switches();
    for (int k = 0; k < 64; k += 13) begin
      sw = 6'(k);
      wr(ADDR, 32'hEC00_0000);
      rdchk(ADDR, "switches", 32'hEC00_0000, {sw[5] | sw[2], sw[4], sw[3] | sw[2], 1'b0, ~sw[1], ~sw[0], 26'h0});
    end
  endtask
  // Control bits read back and drive their outputs, set then clear.
  task automatic t_controls();
    logic [31:0] v [2] = '{32'h0380_A000, 32'h0};
    foreach (v[i]) begin
      wr(ADDR, v[i]);
      rdchk(ADDR, "controls", 32'h0380_A000, v[i]);
      `CHECK("run lamp", ~v[i][24], run_lamp_out_n_o)
      `CHECK("even force", v[i][23], force_bad_parity_even_o)
      `CHECK("odd force", v[i][15], force_bad_parity_odd_o)
      `CHECK("bad node", v[i][25], node_failed_out_n_o)
      `CHECK("leds", {2{v[i][25]}}, selftest_led_o)
      `CHECK("pipe", v[i][13], pipeline_enable_o)
    end
    wr(ADDR + 32'h4, 32'hFFFF_FFFF);
    rdchk(ADDR + 32'h4, "foreign read", 32'hFFFF_FFFF, 32'h0);
    rdchk(ADDR, "untouched", 32'h13FF_E000, 32'h0);
  endtask
  // Write flag tracks the acknowledged kind; io writes stop pipelining.
  task automatic t_txn();
    logic extra_next_cycle_enable;
    pulse_ack(1'b1);
    rdchk(ADDR, "write flag", 32'h0020_0000, 32'h0020_0000);
    pulse_ack(1'b0);
    rdchk(ADDR, "write flag", 32'h0020_0000, 32'h0);
    extra_next_cycle_enable = 1'b1;
    wr(ADDR, 32'h0000_2000);
    rdchk(ADDR, "pipe pairing", 32'h0000_2000, {18'h0, extra_next_cycle_enable, 13'h0});
    txn_i.is_io_write = 1'b1;
    repeat (2) @(negedge clock_i);
    `CHECK("io pipe", 1'b0, pipeline_enable_o)
    `CHECK("io nopipe", 1'b1, io_write_nopipe_o)
    txn_i.is_io_write = 1'b0;
    repeat (2) @(negedge clock_i);
    `CHECK("pipe back", 1'b1, pipeline_enable_o)
    `CHECK("io nopipe off", 1'b0, io_write_nopipe_o)
  endtask
  // Every event code: errors lock with the write flag, only a 1 releases.
  task automatic t_events();
    logic e;
    pulse_ack(1'b1);
    for (int c = 0; c < 32; c++) begin
      e = (c == 3) || (c >= 24 && c != 27);
      bus_event_code_i = 5'(c);
      @(negedge clock_i);
      `CHECK("machine check", e, machine_check_o)
      @(negedge clock_i);
      rdchk(ADDR, "event field", 32'h007F_0000, {9'h0, e, 1'b1, 5'(c), 16'h0});
      if (e) begin
        bus_event_code_i = 5'h00;
        rdchk(ADDR, "held event", 32'h007F_0000, {9'h0, 2'b11, 5'(c), 16'h0});
        wr(ADDR, 32'h0);
        rdchk(ADDR, "lock kept", 32'h0040_0000, 32'h0040_0000);
        wr(ADDR, 32'h0040_0000);
        rdchk(ADDR, "released", 32'h007F_0000, 32'h0020_0000);
      end
    end
  endtask
  // Each lane under each mask: masked lanes never flag, the flag clears by writing 1.
  task automatic t_parity();
    logic [31:0] mk;
    for (int m = 0; m < 2; m++) begin
      mk = m ? 32'h0080_0000 : 32'h0000_8000;
      wr(ADDR, mk);
      for (int l = 0; l < 4; l++) begin
        cache_parity_bad_i = 4'(1 << l);
        cache_read_valid_i = 1'b1;
        @(negedge clock_i);
        `CHECK("error out", (l % 2) != m, port_error_out_n_o)
        cache_parity_bad_i = 4'h0;
        cache_read_valid_i = 1'b0;
        rdchk(ADDR, "parity flag", 32'h0000_4000, ((l % 2) == m) ? 32'h0000_4000 : 32'h0);
        wr(ADDR, mk | 32'h0000_4000);
        rdchk(ADDR, "parity clear", 32'h0000_4000, 32'h0);
      end
    end
  endtask
  // System reset cycles AC then DC low, and DC-low wipes the register.
  task automatic t_sysreset();
    wr(ADDR, 32'h1380_A000);
    for (int i = 0; i < 40 && dc_power_low_n_o !== 1'b0; i++) @(negedge clock_i);
    if (dc_power_low_n_o !== 1'b0) give_up();
    `CHECK("reset out", 1'b0, system_reset_out_n_o)
    `CHECK("ac low", 1'b0, ac_power_low_n_o)
    for (int i = 0; i < 40 && dc_power_low_n_o !== 1'b1; i++) @(negedge clock_i);
    if (dc_power_low_n_o !== 1'b1) give_up();
    repeat (5) @(negedge clock_i);
    rdchk(ADDR, "after reset", 32'h13FF_E000, 32'h0);
    `CHECK("bad node", 1'b0, node_failed_out_n_o)
  endtask

  // Main sequence.
  initial begin
    rst_i = 1'b1;
    req_i = '0;
    txn_i = '0;
    sw = 6'h0;
    bus_event_code_i = 5'h00;
    cache_parity_bad_i = 4'h0;
    cache_read_valid_i = 1'b0;
    repeat (10) @(negedge clock_i);
    rst_i = 1'b0;
    t_switches();
    t_controls();
    t_txn();
    t_events();
    t_parity();
    t_sysreset();
    print_verdict();
  end
endmodule
